// ### ddrt_diag_record.sv
// Diagnostic record bank with microsecond ticker and diagnostic interrupt sequencing.
// Assumes cause inputs are synchronous to CLK_IN; event inputs are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

module ddrt_diag_record (
	input  wire logic             CLK_IN,
	input  wire logic             RESET_IN,
	input  wire logic             DIAG_ENABLE_IN,
	input  wire ddrt_pkg::ddrt_cause_t CAUSE_IN,
	input  wire logic             DIAG_ACK_IN,
	input  wire ddrt_pkg::ddrt_req_t   REQ_IN,
	output var  ddrt_pkg::ddrt_rsp_t   RSP_OUT,
	output logic                  DIAG_INCOMING_OUT,
	output logic                  DIAG_GOING_OUT,
	output logic                  DIAG_ACTIVE_OUT,
	output logic [31:0]           TICKER_OUT
);
	import ddrt_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Record byte decode, shared by the read path and the checks.

	function automatic logic [7:0] rec_byte(input ddrt_state_t s, input logic [4:0] idx);
		logic [7:0] b;
		b = 8'h00;
		if (idx == BYTE_DIAG) begin
			b[BIT_MOD_FAIL] = s.flags.mod_fail;
			b[BIT_EXT_ERR]  = s.flags.ext_err;
			b[BIT_CHAN_ERR] = |s.flags.edge_lost;
		end else if (idx == BYTE_MODINFO) begin
			b[3:0] = MOD_CLASS_DIG;
			b[BIT_CH_INFO] = 1'b1;
		end else if (idx == BYTE_INTDIAG) begin
			b[BIT_OVERFLOW] = s.flags.buf_ovf;
			b[BIT_IRQ_LOST] = s.flags.irq_lost;
		end else if (idx == BYTE_CHKIND) begin
			b[6:0] = CH_KIND_DI;
		end else if (idx == BYTE_BITSPERCH) begin
			b = BITS_PER_CH;
		end else if (idx == BYTE_CHCOUNT) begin
			b = CH_COUNT;
		end else if (idx == BYTE_LOSTEDGE) begin
			b[NUM_INPUTS-1:0] = s.flags.edge_lost;
		end else if (idx >= BYTE_STAMP0 && idx < LEN_FULL) begin
			b = s.stamp[8*(idx - BYTE_STAMP0) +: 8];
		end else begin
			b = 8'h00;
		end
		return b;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State update.

	ddrt_state_t q;
	ddrt_state_t d;
	logic        cause_now;
	logic        cause_next;

	assign cause_now = q.flags.mod_fail | q.flags.ext_err | q.flags.buf_ovf | q.flags.irq_lost
		| (|q.flags.edge_lost);

	always_comb begin
		d = q;
		d.irq_in  = 1'b0;
		d.irq_go  = 1'b0;
		d.rsp.ack = 1'b0;
		d.rsp.err = 1'b0;
		d.tick    = 1'b0;

		if (q.div == TICK_LAST) begin
			d.div  = 5'h00;
			d.tick = 1'b1;
		end else begin
			d.div = q.div + 5'h01;
		end
		if (q.tick) begin
			d.ticker = q.ticker + 32'h0000_0001;
		end

		// Failure and external error follow their causes; the rest stay until acknowledged.
		d.flags.mod_fail = CAUSE_IN.mod_fail;
		d.flags.ext_err  = CAUSE_IN.ext_err;
		if (DIAG_ACK_IN) begin
			d.flags.buf_ovf   = 1'b0;
			d.flags.irq_lost  = 1'b0;
			d.flags.edge_lost = '0;
		end
		if (CAUSE_IN.buf_ovf) begin
			d.flags.buf_ovf = 1'b1;
		end
		if (CAUSE_IN.irq_lost) begin
			d.flags.irq_lost = 1'b1;
		end
		if (q.phase == PH_IDLE) begin
			d.flags.edge_lost = d.flags.edge_lost | CAUSE_IN.edge_lost;
		end

		cause_next = d.flags.mod_fail | d.flags.ext_err | d.flags.buf_ovf | d.flags.irq_lost
			| (|d.flags.edge_lost);

		case (q.phase)
			PH_IDLE: begin
				if (cause_next) begin
					d.phase = PH_ACTIVE;
					d.stamp = q.ticker;
					d.irq_in = DIAG_ENABLE_IN;
				end
			end
			PH_ACTIVE: begin
				// A cause other than a lost edge that returns in the closing cycle keeps the window open, so no going pulse is sent early.
				if (!cause_now && !cause_next) begin
					d.phase = PH_IDLE;
					d.irq_go = DIAG_ENABLE_IN;
				end
			end
			default: begin
				d.phase = PH_IDLE;
			end
		endcase

		// Writes are answered so the coupler never hangs, but nothing is stored.
		if (REQ_IN.wr) begin
			d.rsp.ack  = 1'b1;
			d.rsp.err  = 1'b1;
			d.rsp.data = 8'h00;
		end else if (REQ_IN.rd) begin
			d.rsp.ack = 1'b1;
			if (REQ_IN.set == SET_FULL && REQ_IN.idx < LEN_FULL) begin
				d.rsp.data = rec_byte(q, REQ_IN.idx);
			end else if (REQ_IN.set == SET_SHORT && REQ_IN.idx < LEN_SHORT) begin
				d.rsp.data = rec_byte(q, REQ_IN.idx);
			end else begin
				d.rsp.err  = 1'b1;
				d.rsp.data = 8'h00;
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			q <= '{div: 5'h00, tick: 1'b0, ticker: 32'h0000_0000, flags: '0, phase: PH_IDLE,
				stamp: 32'h0000_0000, rsp: '0, irq_in: 1'b0, irq_go: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign RSP_OUT           = q.rsp;
	assign DIAG_INCOMING_OUT = q.irq_in;
	assign DIAG_GOING_OUT    = q.irq_go;
	assign DIAG_ACTIVE_OUT   = (q.phase == PH_ACTIVE);
	assign TICKER_OUT        = q.ticker;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	logic [7:0] chk_diag;
	logic [7:0] chk_int;
	logic [7:0] chk_info;
	assign chk_diag = rec_byte(q, BYTE_DIAG);
	assign chk_int  = rec_byte(q, BYTE_INTDIAG);
	assign chk_info = rec_byte(q, BYTE_MODINFO);

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);

	tick_period_a: assert property (q.tick |-> ##20 q.tick)
		else $error("microsecond tick period wrong");
	ticker_step_a: assert property (q.tick |=> q.ticker == $past(q.ticker) + 32'h0000_0001)
		else $error("ticker did not step by one");
	ticker_hold_a: assert property (!q.tick |=> $stable(q.ticker))
		else $error("ticker moved without a tick");
	diag_byte_a: assert property (chk_diag[3] == (|q.flags.edge_lost) && chk_diag[1] == 1'b0
		&& chk_diag[7:4] == 4'h0)
		else $error("channel error summary wrong");
	fail_follow_a: assert property (CAUSE_IN.mod_fail |=> chk_diag[0] && q.phase == PH_ACTIVE)
		else $error("module failure not reported");
	overflow_set_a: assert property (CAUSE_IN.buf_ovf |=> chk_int[3])
		else $error("overflow flag not set");
	irq_lost_set_a: assert property (CAUSE_IN.irq_lost |=> chk_int[6] && chk_int[5:4] == 2'b00)
		else $error("lost interrupt flag not set");
	info_byte_a: assert property (chk_info == 8'h1f)
		else $error("module information byte wrong");
	incoming_irq_a: assert property (q.phase == PH_IDLE ##1 q.phase == PH_ACTIVE
		|-> q.irq_in == $past(DIAG_ENABLE_IN) && q.stamp == $past(q.ticker))
		else $error("incoming interrupt or stamp missing");
	going_irq_a: assert property (q.phase == PH_ACTIVE && !cause_now && !cause_next && DIAG_ENABLE_IN
		|=> q.irq_go && q.phase == PH_IDLE)
		else $error("going interrupt missing");
	discard_edges_a: assert property (q.phase == PH_ACTIVE && !DIAG_ACK_IN
		|=> q.flags.edge_lost == $past(q.flags.edge_lost))
		else $error("edge stored while diagnostic active");
	stamp_hold_a: assert property (q.phase == PH_ACTIVE ##1 q.phase == PH_ACTIVE |-> $stable(q.stamp))
		else $error("stamp changed while active");
	short_set_a: assert property (REQ_IN.rd && !REQ_IN.wr && REQ_IN.set == SET_SHORT
		&& REQ_IN.idx >= LEN_SHORT |=> q.rsp.ack && q.rsp.err)
		else $error("short record overrun not refused");
	write_ignored_a: assert property (REQ_IN.wr |=> q.rsp.ack && q.rsp.err && $stable(q.stamp))
		else $error("write not refused");
	kind_read_a: assert property (REQ_IN.rd && !REQ_IN.wr && REQ_IN.set == SET_FULL
		&& REQ_IN.idx == BYTE_CHKIND |=> q.rsp.data == 8'h70 && !q.rsp.err)
		else $error("channel kind byte wrong");
	bits_read_a: assert property (REQ_IN.rd && !REQ_IN.wr && REQ_IN.set == SET_FULL
		&& REQ_IN.idx == BYTE_BITSPERCH |=> q.rsp.data == 8'h00 && !q.rsp.err)
		else $error("bits per channel byte wrong");
	count_read_a: assert property (REQ_IN.rd && !REQ_IN.wr && REQ_IN.set == SET_FULL
		&& REQ_IN.idx == BYTE_CHCOUNT |=> q.rsp.data == 8'h04 && !q.rsp.err)
		else $error("channel count byte wrong");
	lost_map_a: assert property (q.phase == PH_IDLE
		|=> (q.flags.edge_lost & $past(CAUSE_IN.edge_lost)) == $past(CAUSE_IN.edge_lost))
		else $error("lost edge not recorded");
	reserved_read_a: assert property (REQ_IN.rd && !REQ_IN.wr && REQ_IN.set == SET_FULL
		&& REQ_IN.idx >= BYTE_CHRSVD0 && REQ_IN.idx < BYTE_STAMP0 |=> q.rsp.data == 8'h00 && !q.rsp.err)
		else $error("reserved byte not zero");

	incoming_c: cover property (q.irq_in);
	going_c: cover property (q.irq_in ##[1:200] q.irq_go);
	full_read_c: cover property (REQ_IN.rd && REQ_IN.set == SET_FULL && REQ_IN.idx == BYTE_STAMP0
		##1 q.rsp.ack && !q.rsp.err);
	discard_c: cover property (q.phase == PH_ACTIVE && |CAUSE_IN.edge_lost);

endmodule

`default_nettype wire

// ### ddrt_pkg.sv
// Constants, record layout and carrier types for the diagnostic record of a four-input module.
// Assumes a single 20 MHz clock and a bus coupler that reads the record one byte at a time.
//
// Contract
// - Diagnostic byte 0: bit0 module failure, bit2 external error, bit3 channel error.
// - Module information byte carries class 1111b in bits 3 to 0.
// - Module information bit 4 says per-channel information is present.
// - Diagnostic byte 3 bit 3 flags an internal diagnostics buffer overflow.
// - Diagnostic byte 3 bit 6 flags a lost process interrupt.
// - Channel kind byte reads 70h, meaning digital input, bit 7 zero.
// - Diagnostic bits per channel byte always reads 00h.
// - Channel count byte always reads 04h.
// - Lost-edge map bit n is set when an edge on input n was lost.
// - Four record bytes hold the ticker value sampled when the diagnostic arose.
// - A free-running 32-bit counter increments once every microsecond.
// - The counter starts at zero after reset and wraps to zero after its maximum.
// - Incoming interrupt when a cause arises, going interrupt once all causes vanish.
// - Channel events between incoming and going interrupts are discarded.
package ddrt_pkg;

	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned TICK_US       = 1;
	localparam int unsigned TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_US;
	localparam logic [4:0]  TICK_LAST     = 5'(TICK_CYCLES - 1);

	localparam int unsigned NUM_INPUTS    = 4;

	localparam logic [7:0] SET_SHORT      = 8'h00;
	localparam logic [7:0] SET_FULL       = 8'h01;
	localparam logic [4:0] LEN_SHORT      = 5'h04;
	localparam logic [4:0] LEN_FULL       = 5'h14;

	localparam logic [4:0] BYTE_DIAG      = 5'h00;
	localparam logic [4:0] BYTE_MODINFO   = 5'h01;
	localparam logic [4:0] BYTE_RSVD      = 5'h02;
	localparam logic [4:0] BYTE_INTDIAG   = 5'h03;
	localparam logic [4:0] BYTE_CHKIND    = 5'h04;
	localparam logic [4:0] BYTE_BITSPERCH = 5'h05;
	localparam logic [4:0] BYTE_CHCOUNT   = 5'h06;
	localparam logic [4:0] BYTE_LOSTEDGE  = 5'h07;
	localparam logic [4:0] BYTE_CHRSVD0   = 5'h08;
	localparam logic [4:0] BYTE_STAMP0    = 5'h10;

	localparam int unsigned BIT_MOD_FAIL  = 0;
	localparam int unsigned BIT_EXT_ERR   = 2;
	localparam int unsigned BIT_CHAN_ERR  = 3;
	localparam int unsigned BIT_OVERFLOW  = 3;
	localparam int unsigned BIT_IRQ_LOST  = 6;
	localparam int unsigned BIT_CH_INFO   = 4;

	localparam logic [3:0] MOD_CLASS_DIG  = 4'hf;
	localparam logic [6:0] CH_KIND_DI     = 7'h70;
	localparam logic [7:0] BITS_PER_CH    = 8'h00;
	localparam logic [7:0] CH_COUNT       = 8'h04;

	typedef enum logic {PH_IDLE, PH_ACTIVE} ddrt_phase_t;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] set;
		logic [4:0] idx;
	} ddrt_req_t;

	typedef struct packed {
		logic       ack;
		logic       err;
		logic [7:0] data;
	} ddrt_rsp_t;

	typedef struct packed {
		logic                  mod_fail;
		logic                  ext_err;
		logic                  buf_ovf;
		logic                  irq_lost;
		logic [NUM_INPUTS-1:0] edge_lost;
	} ddrt_cause_t;

	typedef struct packed {
		logic [4:0]  div;
		logic        tick;
		logic [31:0] ticker;
		ddrt_cause_t flags;
		ddrt_phase_t phase;
		logic [31:0] stamp;
		ddrt_rsp_t   rsp;
		logic        irq_in;
		logic        irq_go;
	} ddrt_state_t;

endpackage

// ### ddrt_reader.sv
// Bus coupler model that fetches bytes of the diagnostic record.
// Assumes its caller starts each transfer just after a falling edge of the clock.
`timescale 1ns/1ps
`default_nettype none
module ddrt_reader (
	input  wire logic               clk_in,
	input  wire ddrt_pkg::ddrt_rsp_t rsp_in,
	output var  ddrt_pkg::ddrt_req_t req_out
);
	import ddrt_pkg::*;
	initial req_out = '0;
	////////////////////////////////////////////////////////////////
	// record set fetch
	task automatic xfer(input logic w, input logic [7:0] s, input logic [4:0] i,
		output logic [7:0] d, output logic e);
		int n;
		n = 0;
		req_out = '{rd: !w, wr: w, set: s, idx: i};
		@(negedge clk_in);
		// Released lines show the inverse so a stale value cannot pass.
		req_out = '{rd: 1'b0, wr: 1'b0, set: ~s, idx: ~i};
		while (rsp_in.ack !== 1'b1 && n < 4) begin
			@(negedge clk_in);
			n++;
		end
		d = rsp_in.data;
		e = (n < 4) ? rsp_in.err : 1'bx;
		// One idle cycle passes between transfers, so the request is never set twice in one step.
		@(negedge clk_in);
	endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the diagnostic record bank.
// Assumes the reader model and one 20 MHz clock; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ddrt_pkg::*;
	logic        clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic        en_in = 1'b1;
	logic        ack_in = 1'b0;
	ddrt_cause_t cause_in = '0;
	ddrt_req_t   req;
	ddrt_rsp_t   rsp;
	logic        inc;
	logic        go;
	logic        act;
	logic [31:0] tick;
	int          errors = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          wd = 0;
	ddrt_diag_record dut (.CLK_IN(clk_in), .RESET_IN(reset_in), .DIAG_ENABLE_IN(en_in),
		.CAUSE_IN(cause_in), .DIAG_ACK_IN(ack_in), .REQ_IN(req), .RSP_OUT(rsp),
		.DIAG_INCOMING_OUT(inc), .DIAG_GOING_OUT(go), .DIAG_ACTIVE_OUT(act), .TICKER_OUT(tick));
	ddrt_reader reader (.clk_in(clk_in), .rsp_in(rsp), .req_out(req));
	initial forever #25 clk_in = ~clk_in;
	////////////////////////////////////////////////////////////////
	// A hung handshake is cut short well past the expected run length.
	always @(posedge clk_in) begin
		cyc <= reset_in ? 0 : cyc + 1;
		wd <= wd + 1;
		if (wd == 5000) begin
			errors++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("Counts: %0d mismatches in %0d comparisons", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [7:0] s, input logic [4:0] i, input logic [7:0] x, input logic xe);
		logic [7:0] d;
		logic       e;
		reader.xfer(1'b0, s, i, d, e);
		check({24'h0, d}, {24'h0, x});
		check({31'h0, e}, {31'h0, xe});
	endtask
	task automatic mid_tick();
		while (cyc % 20 != 10) @(negedge clk_in);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (act !== 1'b0 && n < 8) begin
			@(negedge clk_in);
			n++;
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_ticker();
		check(tick, 32'h0);
		for (int k = 0; k < 3; k++) begin
			mid_tick();
			check(tick, 32'(cyc / 20));
			@(negedge clk_in);
		end
		$display("t_ticker done");
	endtask
	task automatic t_const();
		logic [7:0] k[8] = '{8'h00, 8'h1f, 8'h00, 8'h00, 8'h70, 8'h00, 8'h04, 8'h00};
		logic [7:0] d;
		logic       e;
		for (int i = 0; i < 16; i++) rd(SET_FULL, 5'(i), (i < 8) ? k[i] : 8'h00, 1'b0);
		rd(SET_SHORT, BYTE_MODINFO, 8'h1f, 1'b0);
		rd(SET_FULL, 5'h14, 8'h00, 1'b1);
		rd(SET_SHORT, 5'h04, 8'h00, 1'b1);
		rd(8'h02, BYTE_DIAG, 8'h00, 1'b1);
		reader.xfer(1'b1, SET_FULL, BYTE_RSVD, d, e);
		check({31'h0, e}, 32'h1);
		rd(SET_FULL, BYTE_RSVD, 8'h00, 1'b0);
		$display("t_const done");
	endtask
	task automatic t_edge();
		logic [31:0] st;
		mid_tick();
		st = 32'(cyc / 20);
		cause_in.edge_lost = 4'b0001;
		@(negedge clk_in);
		cause_in = '0;
		check({30'h0, act, inc}, 32'h3);
		rd(SET_FULL, BYTE_LOSTEDGE, 8'h01, 1'b0);
		rd(SET_FULL, BYTE_DIAG, 8'h08, 1'b0);
		for (int j = 0; j < 4; j++) rd(SET_FULL, 5'(16 + j), st[8*j +: 8], 1'b0);
		cause_in.edge_lost = 4'b0010;
		@(negedge clk_in);
		cause_in = '0;
		rd(SET_FULL, BYTE_LOSTEDGE, 8'h01, 1'b0);
		ack_in = 1'b1;
		@(negedge clk_in);
		ack_in = 1'b0;
		while (go !== 1'b1 && cyc < 4000) @(negedge clk_in);
		check({30'h0, go, act}, 32'h2);
		rd(SET_FULL, BYTE_DIAG, 8'h00, 1'b0);
		$display("t_edge done");
	endtask
	task automatic t_int();
		en_in = 1'b0;
		cause_in = '{mod_fail: 1'b1, ext_err: 1'b1, buf_ovf: 1'b1, irq_lost: 1'b1, edge_lost: 4'h0};
		@(negedge clk_in);
		cause_in = '{mod_fail: 1'b1, ext_err: 1'b1, buf_ovf: 1'b0, irq_lost: 1'b0, edge_lost: 4'h0};
		check({30'h0, act, inc}, 32'h2);
		rd(SET_SHORT, BYTE_INTDIAG, 8'h48, 1'b0);
		rd(SET_FULL, BYTE_DIAG, 8'h05, 1'b0);
		cause_in = '0;
		ack_in = 1'b1;
		@(negedge clk_in);
		ack_in = 1'b0;
		wait_idle();
		check({31'h0, act}, 32'h0);
		$display("t_int done");
	endtask
	task automatic t_reset();
		cause_in.buf_ovf = 1'b1;
		@(negedge clk_in);
		cause_in = '0;
		check({31'h0, act}, 32'h1);
		reset_in = 1'b1;
		repeat (2) @(negedge clk_in);
		reset_in = 1'b0;
		@(negedge clk_in);
		check({31'h0, act}, 32'h0);
		check(tick, 32'h0);
		rd(SET_SHORT, BYTE_INTDIAG, 8'h00, 1'b0);
		repeat (25) @(negedge clk_in);
		mid_tick();
		check(tick, 32'(cyc / 20));
		$display("t_reset done");
	endtask
	initial begin
		repeat (8) @(negedge clk_in);
		reset_in = 1'b0;
		@(negedge clk_in);
		t_ticker();
		t_const();
		t_edge();
		t_int();
		t_reset();
		print_verdict();
	end
endmodule
`default_nettype wire
